// [design/internal_clock_result_shifter.sv]
// Output sequencing of a converter that makes its own serial clock.
// Assumes: conv_done/conv_result come from modulator logic on clk; sck_i and
// cs_below come from pads; link_clk is the free-running internal oscillator.
`include "shifter_defs.svh"

module internal_clock_result_shifter
#(
  parameter int POR_CYCLES = `POR_CYCLES_DFLT,
  parameter int SCK_HALF = `SCK_HALF_DFLT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic sck_i,
  input wire logic cs_below,
  input wire logic conv_done,
  input wire shifter_pkg::result_t conv_result,
  output shifter_pkg::pad_ctl_t pad,
  output logic conv_run,
  output logic ext_mode,
  output shifter_pkg::link_pins_t pins
);
  import shifter_pkg::*;

  // ---------------------------------------------------------------
  // Core domain: pad and done-toggle synchronisers
  // ---------------------------------------------------------------
  logic sck_m, sck_s;
  logic cs_m, cs_s;
  logic dn_m, dn_s, dn_d;
  logic done_evt;
  logic done_tog_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      cs_m <= 1'b0;
      cs_s <= 1'b0;
      dn_m <= 1'b0;
      dn_s <= 1'b0;
      dn_d <= 1'b0;
    end
    else
    begin
      sck_m <= sck_i;
      sck_s <= sck_m;
      cs_m <= cs_below;
      cs_s <= cs_m;
      dn_m <= done_tog_r;
      dn_s <= dn_m;
      dn_d <= dn_s;
    end
  end

  assign done_evt = dn_s ^ dn_d;

  // ---------------------------------------------------------------
  // Core domain: mode selection and conversion cycle
  // ---------------------------------------------------------------
  core_state_t cst_r;
  logic [31:0] por_cnt_r;
  logic int_en_r;
  logic auto_r;
  logic sleep_tog_r;
  logic go_tog_r;
  result_t word_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cst_r <= ST_POR;
      por_cnt_r <= 32'h0;
      int_en_r <= 1'b0;
      auto_r <= 1'b0;
      sleep_tog_r <= 1'b0;
      go_tog_r <= 1'b0;
      word_r <= '0;
      conv_run <= 1'b0;
      ext_mode <= 1'b0;
      pad <= '{cs_pu_en: 1'b0, cs_sink_en: 1'b0, sck_pu_en: 1'b1};
    end
    else
    begin
      case (cst_r)
        ST_POR:
        begin
          por_cnt_r <= por_cnt_r + 32'h1;
          // Strap is read from the synchronised pad, never at reset itself
          if (por_cnt_r == 32'(POR_CYCLES - 1))
          begin
            if (sck_s)
            begin
              // Pull-up stays on until the link drives the clock high: no false edge
              cst_r <= ST_CONV;
              int_en_r <= 1'b1;
              conv_run <= 1'b1;
              pad.cs_pu_en <= 1'b1;
            end
            else
            begin
              cst_r <= ST_EXT;
              pad.sck_pu_en <= 1'b0;
              ext_mode <= 1'b1;
            end
          end
        end
        ST_CONV:
        begin
          // Select still low during conversion despite the pull-up means a timing capacitor
          auto_r <= !cs_s;
          if (conv_done)
          begin
            word_r <= conv_result;
            sleep_tog_r <= !sleep_tog_r;
            cst_r <= ST_SLEEP;
            conv_run <= 1'b0;
            pad.cs_pu_en <= 1'b0;
            pad.cs_sink_en <= auto_r;
            pad.sck_pu_en <= auto_r;
          end
        end
        ST_SLEEP:
        begin
          if (cs_s)
          begin
            pad.cs_sink_en <= 1'b0;
            pad.sck_pu_en <= 1'b0;
            // Continuous mode never crosses, so the clock pin is not re-read
            if (!auto_r || sck_s)
            begin
              go_tog_r <= !go_tog_r;
              cst_r <= ST_XFER;
            end
            else
            begin
              cst_r <= ST_EXT;
              int_en_r <= 1'b0;
              ext_mode <= 1'b1;
            end
          end
        end
        ST_XFER:
        begin
          if (done_evt)
          begin
            cst_r <= ST_CONV;
            conv_run <= 1'b1;
            pad.cs_pu_en <= 1'b1;
          end
        end
        ST_EXT:
        begin
          // External clock operation is not served here; pads stay released
          cst_r <= ST_EXT;
        end
        default:
        begin
          cst_r <= ST_POR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Link domain: reset release and crossings
  // ---------------------------------------------------------------
  logic lrst_m, lrst_n_r;
  logic en_m, en_s, au_m, au_s;
  logic sl_m, sl_s, sl_d, go_m, go_s, go_d;
  logic sleep_evt, go_evt;

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      lrst_m <= 1'b0;
      lrst_n_r <= 1'b0;
    end
    else
    begin
      lrst_m <= 1'b1;
      lrst_n_r <= lrst_m;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      en_m <= 1'b0;
      en_s <= 1'b0;
      au_m <= 1'b0;
      au_s <= 1'b0;
      sl_m <= 1'b0;
      sl_s <= 1'b0;
      sl_d <= 1'b0;
      go_m <= 1'b0;
      go_s <= 1'b0;
      go_d <= 1'b0;
    end
    else
    begin
      en_m <= int_en_r;
      en_s <= en_m;
      au_m <= auto_r;
      au_s <= au_m;
      sl_m <= sleep_tog_r;
      sl_s <= sl_m;
      sl_d <= sl_s;
      go_m <= go_tog_r;
      go_s <= go_m;
      go_d <= go_s;
    end
  end

  assign sleep_evt = sl_s ^ sl_d;
  assign go_evt = go_s ^ go_d;

  // ---------------------------------------------------------------
  // Link domain: clock generation and shifting
  // ---------------------------------------------------------------
  link_state_t lst_r;
  logic [7:0] hcnt_r;
  logic [4:0] rise_r;
  logic [`WORD_BITS-1:0] sh_r;
  logic tick;

  assign tick = (hcnt_r == 8'(SCK_HALF - 1));

  always_ff @(posedge link_clk or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      lst_r <= LK_IDLE;
      hcnt_r <= 8'h0;
      rise_r <= 5'h0;
      sh_r <= '0;
      done_tog_r <= 1'b0;
      pins <= '{sck_o: 1'b1, sck_oe_n: 1'b1, sdo_o: 1'b1, sdo_oe_n: 1'b1};
    end
    else
    begin
      case (lst_r)
        LK_IDLE:
        begin
          pins <= '{sck_o: 1'b1, sck_oe_n: 1'b1, sdo_o: 1'b1, sdo_oe_n: 1'b1};
          if (en_s)
          begin
            lst_r <= LK_CONV;
            pins <= '{sck_o: 1'b1, sck_oe_n: 1'b0, sdo_o: 1'b1, sdo_oe_n: 1'b0};
          end
        end
        LK_CONV:
        begin
          if (!en_s)
            lst_r <= LK_IDLE;
          else if (sleep_evt)
          begin
            lst_r <= LK_SLEEP;
            // In autostart the clock pad is released so the pull-up can act
            pins <= '{sck_o: 1'b0, sck_oe_n: au_s, sdo_o: 1'b0, sdo_oe_n: 1'b0};
          end
        end
        LK_SLEEP:
        begin
          if (!en_s)
            lst_r <= LK_IDLE;
          else if (go_evt)
          begin
            lst_r <= LK_OUT;
            // Core holds word_r still until the done toggle comes back
            sh_r <= {`BUSY_FLAG_DONE, word_r};
            hcnt_r <= 8'h0;
            rise_r <= 5'h0;
            pins.sck_o <= 1'b0;
            pins.sck_oe_n <= 1'b0;
            pins.sdo_o <= `BUSY_FLAG_DONE;
          end
        end
        LK_OUT:
        begin
          hcnt_r <= tick ? 8'h0 : hcnt_r + 8'h1;
          if (rise_r == 5'(`WORD_BITS))
          begin
            // Data rises a link cycle after the last rise, clear of the receiver's hold
            lst_r <= LK_CONV;
            pins.sdo_o <= 1'b1;
            done_tog_r <= !done_tog_r;
          end
          else if (tick && !pins.sck_o)
          begin
            pins.sck_o <= 1'b1;
            rise_r <= rise_r + 5'h1;
          end
          else if (tick)
          begin
            pins.sck_o <= 1'b0;
            sh_r <= {sh_r[`WORD_BITS-2:0], 1'b0};
            pins.sdo_o <= sh_r[`WORD_BITS-2];
          end
        end
        default:
        begin
          lst_r <= LK_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_enter_out;
    lst_r == LK_SLEEP ##1 lst_r == LK_OUT;
  endsequence

  sequence s_last_rise;
    lst_r == LK_OUT && tick && !pins.sck_o && rise_r == `LAST_RISE;
  endsequence

  a_por_select: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_POR && por_cnt_r == 32'(POR_CYCLES - 1)
      |=> (cst_r == ST_CONV) == $past(sck_s) && (cst_r == ST_EXT) == !$past(sck_s))
    else $error("mode not chosen at end of power-on wait");
  a_por_pullup: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_POR |-> pad.sck_pu_en && !conv_run)
    else $error("clock pull-up missing during power-on wait");
  a_conv_high: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    lst_r == LK_CONV |-> pins.sck_o && pins.sdo_o && !pins.sck_oe_n && !pins.sdo_oe_n)
    else $error("clock or data not high while converting");
  a_sleep_low: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    lst_r == LK_CONV && en_s && sleep_evt |=> !pins.sdo_o && !pins.sck_o)
    else $error("pins not low after completion");
  a_sleep_half: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    s_enter_out |-> !pins.sck_o ##1 !pins.sck_o)
    else $error("first clock rise came too early");
  a_frame_end: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    s_last_rise |=> pins.sck_o && $stable(pins.sdo_o)
      ##1 lst_r == LK_CONV && pins.sck_o && pins.sdo_o)
    else $error("frame did not end high after last rise");
  a_data_fall: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    lst_r == LK_OUT && $past(lst_r) == LK_OUT && $changed(pins.sdo_o) |-> $fell(pins.sck_o))
    else $error("data changed away from a falling clock edge");
  a_rise_count: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    lst_r == LK_OUT && $rose(pins.sck_o) |-> rise_r <= 5'(`WORD_BITS) && !pins.sck_oe_n)
    else $error("too many clock rises in one frame");
  a_cs_pullup: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_CONV |-> pad.cs_pu_en && !pad.cs_sink_en && conv_run)
    else $error("select not pulled up during conversion");
  a_sleep_sink: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_CONV && conv_done && auto_r
      |=> cst_r == ST_SLEEP && pad.cs_sink_en && !pad.cs_pu_en && pad.sck_pu_en)
    else $error("select not released into discharge");
  a_auto_start: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_SLEEP && cs_s && sck_s |=> cst_r == ST_XFER ##[1:600] cst_r == ST_CONV)
    else $error("output did not follow the threshold crossing");
  a_restart: assert property (@(posedge clk) disable iff (rst)
    cst_r == ST_XFER && done_evt |=> cst_r == ST_CONV && pad.cs_pu_en && conv_run)
    else $error("no new conversion after the frame");

endmodule

// [design/shifter_defs.svh]
// Constants for the internally clocked result shifter.
// Assumes a 10 MHz core clock and a free-running oscillator on the link clock.
`ifndef SHIFTER_DEFS_SVH
`define SHIFTER_DEFS_SVH

`define CLK_PERIOD_NS 100
`define POR_TIME_NS 500000
`define POR_CYCLES_DFLT ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF_DFLT 4
`define WORD_BITS 24
`define STATUS_BITS 3
`define VALUE_BITS 20
`define LAST_RISE 5'h17
`define BUSY_FLAG_DONE 1'b0

`endif

// [design/shifter_pkg.sv]
// Types shared by the result shifter.
// Assumes shifter_defs.svh is on the include path.
`include "shifter_defs.svh"

package shifter_pkg;

  typedef enum logic [4:0] {
    ST_POR   = 5'h01,
    ST_CONV  = 5'h02,
    ST_SLEEP = 5'h04,
    ST_XFER  = 5'h08,
    ST_EXT   = 5'h10
  } core_state_t;

  typedef enum logic [3:0] {
    LK_IDLE  = 4'h1,
    LK_CONV  = 4'h2,
    LK_SLEEP = 4'h4,
    LK_OUT   = 4'h8
  } link_state_t;

  typedef struct packed {
    logic [`STATUS_BITS-1:0] status;
    logic [`VALUE_BITS-1:0] value;
  } result_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sdo_o;
    logic sdo_oe_n;
  } link_pins_t;

  typedef struct packed {
    logic cs_pu_en;
    logic cs_sink_en;
    logic sck_pu_en;
  } pad_ctl_t;

endpackage

// [tb/result_receiver.sv]
// Receiver of serial result words: shifts data in on each clock rise.
// Assumes resolved pad levels and the bench reset.
module result_receiver
(
  input wire logic rst,
  input wire logic sck,
  input wire logic sdo,
  output logic [23:0] word,
  output int n_words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] sh;
  int nbit;

  always @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      nbit = 0;
      n_words = 0;
    end
    else
    begin
      sh = {sh[22:0], sdo};
      nbit++;
      if (nbit == 24)
      begin
        word = sh;
        nbit = 0;
        n_words++;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Bench for the result shifter: continuous, autostart and strap tests.
// Assumes the design package and a receiver model on the pads.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import shifter_pkg::*;
  logic clk = 0, rst = 1, link_clk = 0, cs_below = 1, conv_done = 0;
  logic sck_ext_low = 0, auto_mode = 0, sck_pad, sdo_pad;
  result_t conv_result = '0;
  pad_ctl_t pad;
  link_pins_t pins;
  logic conv_run, ext_mode;
  logic [23:0] rx_word;
  int rx_n, n_fail = 0, num_checks = 0, cap_cnt = 0;
  logic [23:0] exp_q[$];

  internal_clock_result_shifter #(.POR_CYCLES(20), .SCK_HALF(4)) i_internal_clock_result_shifter
  (
    .clk(clk), .rst(rst), .link_clk(link_clk), .sck_i(sck_pad), .cs_below(cs_below),
    .conv_done(conv_done), .conv_result(conv_result), .pad(pad), .conv_run(conv_run),
    .ext_mode(ext_mode), .pins(pins)
  );
  result_receiver i_result_receiver
  (
    .rst(rst), .sck(sck_pad), .sdo(sdo_pad), .word(rx_word), .n_words(rx_n)
  );

  // Released pads: a held-low driver wins, else pull-up, else a changing level
  assign sck_pad = !pins.sck_oe_n ? pins.sck_o :
                   (sck_ext_low ? 1'b0 : (pad.sck_pu_en ? 1'b1 : ~pins.sck_o));
  assign sdo_pad = !pins.sdo_oe_n ? pins.sdo_o : ~pins.sdo_o;

  initial
  begin
    forever #50 clk = ~clk;
  end
  initial
  begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  // ----------------------------------------
  // Timing capacitor on chip select
  // ----------------------------------------
  always @(posedge clk)
  begin
    #1;
    if (!auto_mode)
      cs_below = 1'b1;
    else if (pad.cs_pu_en || !pad.cs_sink_en)
    begin
      cap_cnt = 0;
      cs_below = 1'b0;
    end
    else
    begin
      cap_cnt++;
      cs_below = (cap_cnt > 6);
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  always @(rx_n)
  begin
    if (rx_n != 0)
    begin
      if (exp_q.size() == 0)
        chk_bit(1'b1, 1'b0);
      else
        chk_word(rx_word, exp_q.pop_front());
    end
  end

  task automatic do_reset(input logic ext);
    rst = 1;
    sck_ext_low = ext;
    repeat (4) @(posedge clk);
    #1 rst = 0;
    repeat (30) @(posedge clk);
    #1;
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (conv_run !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk_bit(conv_run, 1'b1);
  endtask

  // Mode 0 continuous, 1 autostart, 2 autostart with clock pad held low
  task automatic convert(input int mode);
    result_t res;
    res = result_t'($urandom);
    wait_run();
    @(posedge clk);
    #1 conv_done = 1;
    conv_result = res;
    if (mode != 2)
      exp_q.push_back({1'b0, res});
    @(posedge clk);
    #1 conv_done = 0;
    conv_result = result_t'($urandom);
    // One edge on: sleep is showing and the first clock rise is still ahead
    @(posedge clk);
    #1 chk_bit(conv_run, 1'b0);
    if (mode == 0)
    begin
      chk_bit(sck_pad, 1'b0);
      chk_bit(sdo_pad, 1'b0);
    end
    else
    begin
      chk_bit(pad.cs_sink_en, 1'b1);
      chk_bit(pad.cs_pu_en, 1'b0);
      chk_bit(pad.sck_pu_en, 1'b1);
    end
    if (mode == 2)
    begin
      sck_ext_low = 1;
      repeat (30) @(posedge clk);
      #1 chk_bit(ext_mode, 1'b1);
      chk_bit(conv_run, 1'b0);
      return;
    end
    wait_run();
    chk_bit(sdo_pad, 1'b1);
    chk_bit(sck_pad, 1'b1);
    if (mode == 1)
      chk_bit(pad.cs_pu_en, 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(9037));
    do_reset(1'b1);
    chk_bit(ext_mode, 1'b1);
    chk_bit(conv_run, 1'b0);
    $display("test strap_external done");
    do_reset(1'b0);
    chk_bit(ext_mode, 1'b0);
    chk_bit(pad.sck_pu_en, 1'b1);
    chk_bit(rx_n == 0, 1'b1);
    for (int i = 0; i < 3; i++)
      convert(0);
    $display("test continuous done");
    auto_mode = 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2; i++)
      convert(1);
    $display("test autostart done");
    convert(2);
    chk_bit(exp_q.size() == 0, 1'b1);
    $display("test reselect done");
    print_verdict();
  end
endmodule
